/* rtl/ifdpfd_pkg.sv */
/*
  Shared constants and types for the integer-n divider with phase-frequency detector:
  register offsets, field positions, reset values and detector states.
  Assumes a single 25 MHz system clock and an AHB-Lite register bus of 32 bits.
*/
package ifdpfd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] DIVCNT_OFS  = 8'h08;
  localparam logic [7:0] REFCNT_OFS  = 8'h0C;
  localparam logic [7:0] RATIO_OFS   = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MAIN_LSB     = 0;
  localparam int MAIN_W       = 6;
  localparam int SWAL_LSB     = 8;
  localparam int SWAL_W       = 2;
  localparam int POL_BIT      = 16;
  localparam int ST_LOCK_BIT  = 0;
  localparam int ST_UP_BIT    = 1;
  localparam int ST_DN_BIT    = 2;
  localparam int ST_MODE_BIT  = 3;
  localparam int RATIO_W      = 9;

  // ----------------------------------------------------------------
  // reset values and divider constants
  // ----------------------------------------------------------------
  localparam logic [5:0] MAIN_RST     = 6'h02;
  localparam logic [1:0] SWAL_RST     = 2'h0;
  localparam logic       POL_RST      = 1'b0;
  localparam logic [2:0] PRESC_MOD    = 3'h4;
  localparam logic [31:0] DIVCNT_RST  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] main_count_bits;
    logic       swallow_count_bit1;
    logic       swallow_count_bit0;
    logic       detector_polarity_select;
  } ifdpfd_ctrl_t;

  typedef enum logic [2:0] {
    PFD_IDLE = 3'b001,
    PFD_UP   = 3'b010,
    PFD_DN   = 3'b100
  } ifdpfd_state_t;

endpackage

/* rtl/ifdpfd_prescaler.sv */
/*
  Dual-modulus prescaler, divide by 4 or 5, counting qualified input edges.
  Assumes edge pulses already synchronous to mclk; mode is not registered, each edge compares against the current div_by_five.
*/
`timescale 1ns/1ps
module ifdpfd_prescaler
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // edge stream
  input  wire logic edge_pulse,
  input  wire logic div_by_five,
  input  wire logic restart,
  // wrap
  output logic      wrap_pulse
);

  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [2:0] limit;
  logic       at_limit;

  // ----------------------------------------------------------------
  // modulus select
  // ----------------------------------------------------------------
  assign limit    = div_by_five ? ifdpfd_pkg::PRESC_MOD : ifdpfd_pkg::PRESC_MOD - 3'h1;
  assign at_limit = (cnt_reg >= limit);
  assign cnt_next = restart ? 3'h0 :
                    !edge_pulse ? cnt_reg :
                    at_limit ? 3'h0 : cnt_reg + 3'h1;
  assign wrap_pulse = edge_pulse && at_limit && !restart;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      cnt_reg <= 3'h0;
    else
      cnt_reg <= cnt_next;
  end

endmodule

/* rtl/ifdpfd_top.sv */
/*
  Integer-n divider (n = 4*N + S) with phase-frequency detector and lock indicator,
  configured and observed over an AHB-Lite slave.
  Assumes rf and reference pins far slower than mclk; both pass two flip-flops first.
*/
// Summary of operation
// - ratios 12 to 259 all reachable through main and swallow fields.
// - prescaler modulus four; ratio equals four times main plus swallow.
// - main field holds main count minus one; hardware adds one.
// - main field is six bits, bit 0 least significant.
// - swallow field is two bits, no offset, bit 0 least significant.
// - main field one gives ratios 8, 9 and 10 for swallow 0..2.
// - detector compares divided rf with reference; up, down and lock outputs.
// - polarity low gives normal sense, high swaps up and down.
// - lock output pulses; average low unlocked, high locked.
`timescale 1ns/1ps
module ifdpfd_top
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // rf and reference pairs
  input  wire logic        rf_divider_input,
  input  wire logic        rf_divider_input_complement,
  input  wire logic        reference_input,
  input  wire logic        reference_input_complement,
  // detector outputs
  output logic             pump_up_output,
  output logic             pump_down_output,
  output logic             lock_indicator
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ifdpfd_pkg::ifdpfd_ctrl_t  ctrl_reg;
  ifdpfd_pkg::ifdpfd_ctrl_t  ctrl_next;
  ifdpfd_pkg::ifdpfd_state_t st_reg;
  ifdpfd_pkg::ifdpfd_state_t st_next;

  logic [1:0]  rf_p_sync;
  logic [1:0]  rf_n_sync;
  logic [1:0]  ref_p_sync;
  logic [1:0]  ref_n_sync;
  logic        rf_lvl_reg;
  logic        ref_lvl_reg;
  logic        rf_lvl;
  logic        ref_lvl;
  logic        rf_edge;
  logic        ref_edge;

  logic [6:0]  main_left_reg;
  logic [6:0]  main_left_next;
  logic [1:0]  swal_left_reg;
  logic [1:0]  swal_left_next;
  logic        presc_wrap;
  logic        div_pulse_reg;
  logic        div_edge;
  logic        cfg_change;
  logic        five_mode;

  logic        up_raw;
  logic        dn_raw;
  logic        up_reg;
  logic        dn_reg;
  logic        lock_reg;

  logic [31:0] divcnt_reg;
  logic [31:0] refcnt_reg;

  logic        ap_valid;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_reg;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [5:0]  wr_main;
  logic [1:0]  wr_swal;

  // ----------------------------------------------------------------
  // field decoding
  // ----------------------------------------------------------------
  function automatic logic [6:0] eff_main(input logic [5:0] field);
    eff_main = {1'b0, field} + 7'h01;
  endfunction

  function automatic logic [8:0] eff_ratio(input logic [5:0] field, input logic [1:0] sw);
    eff_ratio = {eff_main(field), 2'b00} + {7'h00, sw};
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rf_p_sync  <= 2'h0;
      rf_n_sync  <= 2'h3;
      ref_p_sync <= 2'h0;
      ref_n_sync <= 2'h3;
    end
    else
    begin
      rf_p_sync  <= {rf_p_sync[0], rf_divider_input};
      rf_n_sync  <= {rf_n_sync[0], rf_divider_input_complement};
      ref_p_sync <= {ref_p_sync[0], reference_input};
      ref_n_sync <= {ref_n_sync[0], reference_input_complement};
    end
  end

  // differential decision: true side high and complement low
  assign rf_lvl  = rf_p_sync[1] & ~rf_n_sync[1];
  assign ref_lvl = ref_p_sync[1] & ~ref_n_sync[1];

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rf_lvl_reg  <= 1'b0;
      ref_lvl_reg <= 1'b0;
    end
    else
    begin
      rf_lvl_reg  <= rf_lvl;
      ref_lvl_reg <= ref_lvl;
    end
  end

  assign rf_edge  = rf_lvl & ~rf_lvl_reg;
  assign ref_edge = ref_lvl & ~ref_lvl_reg;

  // ----------------------------------------------------------------
  // pulse-swallow divider
  // ----------------------------------------------------------------
  // swallow is spent while main cycles remain, so s above n clamps
  assign five_mode = (swal_left_reg != 2'h0);

  ifdpfd_prescaler u_presc
  (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .edge_pulse  (rf_edge),
    .div_by_five (five_mode),
    .restart     (cfg_change),
    .wrap_pulse  (presc_wrap)
  );

  // a new ratio restarts the period so no mixed count is emitted
  assign cfg_change = wr_pend_reg && (wr_addr_reg == ifdpfd_pkg::CTRL_OFS);

  // one output edge per 5*S + 4*(N-S) rf edges
  assign div_edge = presc_wrap && (main_left_reg == 7'h01);

  always_comb
  begin
    main_left_next = main_left_reg;
    swal_left_next = swal_left_reg;
    if (cfg_change || div_edge)
    begin
      main_left_next = eff_main(ctrl_next.main_count_bits);
      swal_left_next = {ctrl_next.swallow_count_bit1, ctrl_next.swallow_count_bit0};
    end
    else if (presc_wrap)
    begin
      main_left_next = main_left_reg - 7'h01;
      if (five_mode)
        swal_left_next = swal_left_reg - 2'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      main_left_reg <= eff_main(ifdpfd_pkg::MAIN_RST);
      swal_left_reg <= ifdpfd_pkg::SWAL_RST;
      div_pulse_reg <= 1'b0;
    end
    else
    begin
      main_left_reg <= main_left_next;
      swal_left_reg <= swal_left_next;
      div_pulse_reg <= div_edge;
    end
  end

  // ----------------------------------------------------------------
  // phase-frequency detector
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      ifdpfd_pkg::PFD_IDLE:
      begin
        if (ref_edge && !div_pulse_reg)
          st_next = ifdpfd_pkg::PFD_UP;
        else if (div_pulse_reg && !ref_edge)
          st_next = ifdpfd_pkg::PFD_DN;
      end
      ifdpfd_pkg::PFD_UP:
      begin
        if (div_pulse_reg)
          st_next = ifdpfd_pkg::PFD_IDLE;
      end
      ifdpfd_pkg::PFD_DN:
      begin
        if (ref_edge)
          st_next = ifdpfd_pkg::PFD_IDLE;
      end
      default:
        st_next = ifdpfd_pkg::PFD_IDLE;
    endcase
  end

  assign up_raw = (st_next == ifdpfd_pkg::PFD_UP);
  assign dn_raw = (st_next == ifdpfd_pkg::PFD_DN);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_reg   <= ifdpfd_pkg::PFD_IDLE;
      up_reg   <= 1'b0;
      dn_reg   <= 1'b0;
      lock_reg <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      up_reg   <= ctrl_reg.detector_polarity_select ? dn_raw : up_raw;
      dn_reg   <= ctrl_reg.detector_polarity_select ? up_raw : dn_raw;
      // high between corrections; long pump pulses pull the average low
      lock_reg <= ~(up_raw | dn_raw);
    end
  end

  assign pump_up_output   = up_reg;
  assign pump_down_output = dn_reg;
  assign lock_indicator   = lock_reg;

  // ----------------------------------------------------------------
  // edge counters for software
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      divcnt_reg <= ifdpfd_pkg::DIVCNT_RST;
      refcnt_reg <= ifdpfd_pkg::DIVCNT_RST;
    end
    else
    begin
      if (div_pulse_reg)
        divcnt_reg <= divcnt_reg + 32'h0000_0001;
      if (ref_edge)
        refcnt_reg <= refcnt_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // zero wait states: read data latched in the address phase
  assign ap_valid  = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  assign ctrl_word = {15'h0000, ctrl_reg.detector_polarity_select, 6'h00,
                      ctrl_reg.swallow_count_bit1, ctrl_reg.swallow_count_bit0,
                      2'h0, ctrl_reg.main_count_bits};
  assign status_word = {28'h0000000, five_mode, dn_reg, up_reg, lock_reg};

  assign rd_mux = (haddr[7:0] == ifdpfd_pkg::CTRL_OFS)   ? ctrl_word :
                  (haddr[7:0] == ifdpfd_pkg::STATUS_OFS) ? status_word :
                  (haddr[7:0] == ifdpfd_pkg::DIVCNT_OFS) ? divcnt_reg :
                  (haddr[7:0] == ifdpfd_pkg::REFCNT_OFS) ? refcnt_reg :
                  (haddr[7:0] == ifdpfd_pkg::RATIO_OFS)  ?
                    {23'h000000, eff_ratio(ctrl_reg.main_count_bits,
                     {ctrl_reg.swallow_count_bit1, ctrl_reg.swallow_count_bit0})} :
                  32'h0000_0000;

  assign wr_main = hwdata[ifdpfd_pkg::MAIN_LSB +: ifdpfd_pkg::MAIN_W];
  assign wr_swal = hwdata[ifdpfd_pkg::SWAL_LSB +: ifdpfd_pkg::SWAL_W];

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (cfg_change)
    begin
      ctrl_next.main_count_bits          = wr_main;
      ctrl_next.swallow_count_bit1       = wr_swal[1];
      ctrl_next.swallow_count_bit0       = wr_swal[0];
      ctrl_next.detector_polarity_select = hwdata[ifdpfd_pkg::POL_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
      ctrl_reg    <= '{ifdpfd_pkg::MAIN_RST, ifdpfd_pkg::SWAL_RST[1],
                       ifdpfd_pkg::SWAL_RST[0], ifdpfd_pkg::POL_RST};
    end
    else
    begin
      wr_pend_reg <= ap_valid && hwrite;
      wr_addr_reg <= haddr[7:0];
      if (ap_valid && !hwrite)
        hrdata_reg <= rd_mux;
      ctrl_reg <= ctrl_next;
    end
  end

endmodule

/* test/ifdpfd_sva.sv */
/* Checker beside ifdpfd_top: register readback and detector relations.
   Assumes hready is tied to hreadyout and the bus carries single words. */
`timescale 1ns/1ps
module ifdpfd_sva
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // detector
  input wire logic        rf_divider_input,
  input wire logic        reference_input,
  input wire logic        pump_up_output,
  input wire logic        pump_down_output,
  input wire logic        lock_indicator
);
  // ------
  // shadow of the control word
  // ------
  logic        ap_reg;
  logic        apw_reg;
  logic [7:0]  apa_reg;
  logic [31:0] ctl_reg;
  wire  [6:0]  m_w    = {1'b0, ctl_reg[5:0]} + 7'h01;
  wire  [8:0]  rat_w  = {m_w, 2'h0} + 9'(ctl_reg[9:8]);
  wire         rd_w   = ap_reg & ~apw_reg;
  wire         pump_w = pump_up_output | pump_down_output;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ap_reg  <= 1'b0;
      ctl_reg <= 32'h0000_0002;
    end
    else
    begin
      ap_reg  <= hsel & htrans[1] & hready;
      apw_reg <= hwrite;
      apa_reg <= haddr[7:0];
      if (ap_reg && apw_reg && apa_reg == ifdpfd_pkg::CTRL_OFS)
        ctl_reg <= hwdata;
    end
  end

  // ------
  // properties
  // ------
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_ratio_read: assert property (rd_w && apa_reg == ifdpfd_pkg::RATIO_OFS
    |-> hrdata == {23'h0, rat_w}) else $error("ratio read wrong");
  a_ctrl_read: assert property (rd_w && apa_reg == ifdpfd_pkg::CTRL_OFS
    |-> hrdata == (ctl_reg & 32'h0001_033F)) else $error("control read wrong");
  a_pumps_apart: assert property (!(pump_up_output && pump_down_output))
    else $error("both pumps on");
  a_lock_drops: assert property ($rose(pump_w) |-> ##[0:1] !lock_indicator)
    else $error("lock high while pumping");
  a_lock_returns: assert property ($fell(pump_w) |-> ##[0:2] (lock_indicator || pump_w))
    else $error("lock not back");
  a_lock_low_run: assert property (pump_w [*3] |-> !lock_indicator)
    else $error("lock high in pump run");
  // rf held low so no divided edge can cancel the reference edge
  a_ref_starts: assert property ($rose(reference_input) && !pump_w && !rf_divider_input
    |-> ##[1:6] pump_w) else $error("reference edge ignored");
  a_pump_holds: assert property ((pump_w && $stable(rf_divider_input)
    && $stable(reference_input)) [*8] |=> pump_w) else $error("pump dropped");
endmodule

bind ifdpfd_top ifdpfd_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .rf_divider_input(rf_divider_input), .reference_input(reference_input),
  .pump_up_output(pump_up_output), .pump_down_output(pump_down_output),
  .lock_indicator(lock_indicator));

/* test/ifdpfd_osc_model.sv */
/* Reference oscillator and vco model: square waves on two differential pairs.
   Assumes enables change right after a rising mclk edge. */
`timescale 1ns/1ps
module ifdpfd_osc_model
(
  // clock and control
  input  wire logic mclk,
  input  wire logic rf_en,
  input  wire logic ref_en,
  // differential pairs
  output logic      rf_p,
  output logic      rf_n,
  output logic      ref_p,
  output logic      ref_n
);
  // ------
  // phase counters
  // ------
  // four mclk a period: each level two cycles, the fastest the synchroniser keeps
  logic [1:0] rf_ph_reg  = 2'h0;
  logic [1:0] ref_ph_reg = 2'h0;

  always_ff @(posedge mclk)
  begin
    if (rf_en)
      rf_ph_reg <= rf_ph_reg + 2'h1;
    if (ref_en)
      ref_ph_reg <= ref_ph_reg + 2'h1;
  end

  // a burst of whole periods ends low, so the pairs stand still between bursts
  assign rf_p  = rf_ph_reg[1];
  assign rf_n  = ~rf_ph_reg[1];
  assign ref_p = ref_ph_reg[1];
  assign ref_n = ~ref_ph_reg[1];
endmodule

/* test/testbench.sv */
/* Testbench for ifdpfd_top: bus tasks, ratio table, divider counts, detector.
   Assumes the oscillator model drives both input pairs. */
`timescale 1ns/1ps
module testbench;
  logic        mclk    = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        rf_en   = 1'b0;
  logic        ref_en  = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp_w, rf_p, rf_n, ref_p, ref_n, up, dn, lock;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [5:0]  fl [8] = '{6'h02, 6'h02, 6'h03, 6'h3E, 6'h3F, 6'h01, 6'h01, 6'h01};
  logic [1:0]  sl [8] = '{2'h0, 2'h3, 2'h1, 2'h0, 2'h3, 2'h0, 2'h1, 2'h2};

  always #20 mclk = ~mclk;

  ifdpfd_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp_w), .rf_divider_input(rf_p),
    .rf_divider_input_complement(rf_n), .reference_input(ref_p),
    .reference_input_complement(ref_n), .pump_up_output(up), .pump_down_output(dn),
    .lock_indicator(lock));

  ifdpfd_osc_model u_osc (.mclk(mclk), .rf_en(rf_en), .ref_en(ref_en), .rf_p(rf_p),
    .rf_n(rf_n), .ref_p(ref_p), .ref_n(ref_n));

  // ------
  // tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    q = hrdata;
    chk("hresp", 32'(hresp_w), 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask

  // whole periods only; the wait covers sync, edge detect and pump register
  task automatic burst(input logic on_rf, input int k);
    if (on_rf)
      rf_en <= 1'b1;
    else
      ref_en <= 1'b1;
    repeat (4 * k) @(posedge mclk);
    rf_en  <= 1'b0;
    ref_en <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  // ------
  // sequence
  // ------
  initial
  begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("lock", 32'(lock), 32'h1);
    rdc("ctrl", ifdpfd_pkg::CTRL_OFS, 32'h0000_0002);
    rdc("ratio", ifdpfd_pkg::RATIO_OFS, 32'h0000_000C);
    rdc("unmapped", 8'h40, 32'h0);
    rdc("status", ifdpfd_pkg::STATUS_OFS, 32'h0000_0001);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(ifdpfd_pkg::CTRL_OFS, {22'h0, sl[i], 2'h0, fl[i]});
      rdc("ctrl", ifdpfd_pkg::CTRL_OFS, {22'h0, sl[i], 2'h0, fl[i]});
      rdc("ratio", ifdpfd_pkg::RATIO_OFS, 32'(4 * (fl[i] + 1) + sl[i]));
    end
    $display("ratio table done");
    for (int i = 5; i < 8; i++)
    begin
      wr(ifdpfd_pkg::CTRL_OFS, {22'h0, sl[i], 2'h0, fl[i]});
      burst(1'b1, 3 * (4 * (fl[i] + 1) + sl[i]));
      // the divided-edge count is never cleared, so it grows by three a burst
      rdc("divcnt", ifdpfd_pkg::DIVCNT_OFS, 32'(3 * (i - 4)));
    end
    $display("divider count done");
    chk("down", 32'(dn), 32'h1);
    chk("lock", 32'(lock), 32'h0);
    burst(1'b0, 1);
    chk("pumps", {30'h0, up, dn}, 32'h0);
    chk("lock", 32'(lock), 32'h1);
    burst(1'b0, 1);
    chk("up", {30'h0, up, dn}, 32'h2);
    rdc("refcnt", ifdpfd_pkg::REFCNT_OFS, 32'h2);
    // up pumping, lock low, period starts in divide-by-five for swallow two
    rdc("status", ifdpfd_pkg::STATUS_OFS, 32'h0000_000A);
    burst(1'b1, 10);
    chk("pumps", {30'h0, up, dn}, 32'h0);
    wr(ifdpfd_pkg::CTRL_OFS, 32'h0001_0202);
    burst(1'b0, 1);
    chk("swapped down", {30'h0, up, dn}, 32'h1);
    burst(1'b1, 14);
    burst(1'b1, 14);
    chk("swapped up", {30'h0, up, dn}, 32'h2);
    $display("detector test done");
    close_out();
  end
endmodule
